// ### cols_ext_model.sv
// far-side equipment: pull-up on the collector line and a sinking input
`default_nettype none
module cols_ext_model (
    input wire logic oe,
    input wire logic sink,
    output logic level
);
    timeunit 1ns;
    timeprecision 1ps;
    // pull-up wins unless the camera or the far side sinks the line
    assign level = !(oe || sink);
endmodule
`default_nettype wire

// ### cols_params.svh
// constants for the camera output line source select block
`ifndef COLS_PARAMS_SVH
`define COLS_PARAMS_SVH

// register byte offsets
`define COLS_SEL_OFS 12'h000
`define COLS_CTRL_OFS 12'h004
`define COLS_DEBOUNCE_OFS 12'h008
`define COLS_TRIG_DELAY_OFS 12'h00C
`define COLS_STATUS_OFS 12'h010

// selector register fields
`define COLS_SEL_OPTO_LSB 0
`define COLS_SEL_BIDIR_LSB 8
`define COLS_SEL_W 4

// control register fields
`define COLS_CTRL_USER1_BIT 0
`define COLS_CTRL_USER2_BIT 1
`define COLS_CTRL_BIDIR_OE_BIT 2

// reset values
`define COLS_SEL_RST 4'h0
`define COLS_DEBOUNCE_RST 16'h0010
`define COLS_TRIG_DELAY_RST 16'h0000

// timing
`define COLS_CLK_PERIOD_NS 8
`define COLS_PPS_PERIOD_NS 1000000000
`define COLS_PPS_HALF_CYCLES (`COLS_PPS_PERIOD_NS / 2 / `COLS_CLK_PERIOD_NS)

`endif

// ### cols_pkg.sv
// types for the camera output line source select block
`default_nettype none

package cols_pkg;

    // source codes as written to a line selector
    typedef enum logic [3:0] {
        COLS_SRC_FRAME_TRIG_WAIT = 4'h0,
        COLS_SRC_FRAME_TRIG_INT = 4'h1,
        COLS_SRC_EXPOSURE_ACTIVE = 4'h2,
        COLS_SRC_ACQ_TRIG_WAIT = 4'h3,
        COLS_SRC_ACQ_TRIG_INT = 4'h4,
        COLS_SRC_SENSOR_READOUT = 4'h5,
        COLS_SRC_DEB_OPTO_IN = 4'h6,
        COLS_SRC_DEB_BIDIR = 4'h7,
        COLS_SRC_USER_OUT1 = 4'h8,
        COLS_SRC_USER_OUT2 = 4'h9,
        COLS_SRC_TIMER0 = 4'hA,
        COLS_SRC_SW_SIG0 = 4'hB,
        COLS_SRC_SW_SIG1 = 4'hC,
        COLS_SRC_LOGIC_BLK0 = 4'hD,
        COLS_SRC_PPS = 4'hE
    } cols_src_t;

    // camera core events and levels feeding the sources
    typedef struct packed {
        logic trigger_accepted;
        logic exposure_start;
        logic exposure_end;
        logic image_out_done;
        logic transfer_start;
        logic transfer_done;
        logic frame_valid_flag;
        logic timer0_active;
        logic sw_signal0;
        logic sw_signal1;
        logic logic_block0;
    } cols_cam_t;

    // ahb-lite request from the master
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
        logic [31:0] hwdata;
    } cols_ahb_req_t;

endpackage

`default_nettype wire

// ### cols_top.sv
// camera output line source select with ahb-lite register slave
`include "cols_params.svh"
`default_nettype none

module cols_top #(
    parameter int PPS_HALF_CYCLES = `COLS_PPS_HALF_CYCLES,
    parameter int DEB_W = 16,
    parameter int DLY_W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire cols_pkg::cols_ahb_req_t ahb_req,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire cols_pkg::cols_cam_t cam,
    input wire logic opto_input_line,
    input wire logic bidir_collector_line_in,
    output logic opto_output_line,
    output logic bidir_collector_line_out,
    output logic bidir_collector_line_oe
);
    import cols_pkg::*;

    localparam int PPS_CW = $clog2(PPS_HALF_CYCLES + 1);
    localparam logic [PPS_CW-1:0] PPS_LAST = PPS_CW'(PPS_HALF_CYCLES - 1);

    // --------------------------------------------------------------
    // register state
    // --------------------------------------------------------------
    cols_src_t sel_opto;
    cols_src_t sel_bidir;
    logic user_out1;
    logic user_out2;
    logic bidir_drive_en;
    logic [DEB_W-1:0] deb_time;
    logic [DLY_W-1:0] trig_delay;

    logic wr_pend;
    logic rd_pend;
    logic [11:0] dp_addr;

    // --------------------------------------------------------------
    // source state
    // --------------------------------------------------------------
    logic frame_trig_wait;
    logic frame_trig_int;
    logic exposure_active;
    logic acq_trig_wait;
    logic acq_trig_int;
    logic dly_busy;
    logic [DLY_W-1:0] dly_cnt;
    logic [1:0] deb_level;
    logic [DEB_W-1:0] deb_cnt [2];
    logic [1:0] raw_line;
    logic [PPS_CW-1:0] pps_cnt;
    logic pps;
    logic [14:0] src;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    // map a written selector field onto a source; unused code falls back
    function automatic cols_src_t to_src(input logic [3:0] code);
        cols_src_t s;
        s = COLS_SRC_FRAME_TRIG_WAIT;
        if (code != 4'hF)
        begin
            s = cols_src_t'(code);
        end
        return s;
    endfunction

    // value of the source picked by a selector
    function automatic logic pick(input logic [14:0] v, input cols_src_t s);
        return v[s];
    endfunction

    assign raw_line = {bidir_collector_line_in, opto_input_line};

    assign src = {
        pps,
        cam.logic_block0,
        cam.sw_signal1,
        cam.sw_signal0,
        cam.timer0_active,
        user_out2,
        user_out1,
        deb_level[1],
        deb_level[0],
        cam.frame_valid_flag,
        acq_trig_int,
        acq_trig_wait,
        exposure_active,
        frame_trig_int,
        frame_trig_wait
    };

    // --------------------------------------------------------------
    // ahb-lite slave: writes zero wait, reads one wait state
    // --------------------------------------------------------------
    logic addr_ok;
    assign addr_ok = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            dp_addr <= 12'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else if (ce)
        begin
            wr_pend <= addr_ok && ahb_req.hwrite;
            rd_pend <= addr_ok && !ahb_req.hwrite;
            hreadyout <= !(addr_ok && !ahb_req.hwrite);
            hresp <= 1'b0;
            if (addr_ok)
            begin
                dp_addr <= {ahb_req.haddr[11:2], 2'b00};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h00000000;
        end
        else if (ce && rd_pend)
        begin
            case (dp_addr)
                `COLS_SEL_OFS:
                begin
                    hrdata <= {20'h00000, sel_bidir, 4'h0, sel_opto};
                end
                `COLS_CTRL_OFS:
                begin
                    hrdata <= {29'h00000000, bidir_drive_en, user_out2, user_out1};
                end
                `COLS_DEBOUNCE_OFS:
                begin
                    hrdata <= 32'(deb_time);
                end
                `COLS_TRIG_DELAY_OFS:
                begin
                    hrdata <= 32'(trig_delay);
                end
                `COLS_STATUS_OFS:
                begin
                    hrdata <= {15'h0000, raw_line, src};
                end
                default:
                begin
                    hrdata <= 32'h00000000;
                end
            endcase
        end
    end

    // selectors
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sel_opto <= cols_src_t'(`COLS_SEL_RST);
            sel_bidir <= cols_src_t'(`COLS_SEL_RST);
        end
        else if (ce && wr_pend && dp_addr == `COLS_SEL_OFS)
        begin
            sel_opto <= to_src(ahb_req.hwdata[`COLS_SEL_OPTO_LSB +: `COLS_SEL_W]);
            sel_bidir <= to_src(ahb_req.hwdata[`COLS_SEL_BIDIR_LSB +: `COLS_SEL_W]);
        end
    end

    // user levels and line direction
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            user_out1 <= 1'b0;
            user_out2 <= 1'b0;
            bidir_drive_en <= 1'b0;
        end
        else if (ce && wr_pend && dp_addr == `COLS_CTRL_OFS)
        begin
            user_out1 <= ahb_req.hwdata[`COLS_CTRL_USER1_BIT];
            user_out2 <= ahb_req.hwdata[`COLS_CTRL_USER2_BIT];
            bidir_drive_en <= ahb_req.hwdata[`COLS_CTRL_BIDIR_OE_BIT];
        end
    end

    // timing settings
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            deb_time <= DEB_W'(`COLS_DEBOUNCE_RST);
            trig_delay <= DLY_W'(`COLS_TRIG_DELAY_RST);
        end
        else if (ce && wr_pend)
        begin
            if (dp_addr == `COLS_DEBOUNCE_OFS)
            begin
                deb_time <= ahb_req.hwdata[DEB_W-1:0];
            end
            if (dp_addr == `COLS_TRIG_DELAY_OFS)
            begin
                trig_delay <= ahb_req.hwdata[DLY_W-1:0];
            end
        end
    end

    // --------------------------------------------------------------
    // camera state sources
    // --------------------------------------------------------------
    // busy from exposure start until image out; start wins a tie
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            frame_trig_wait <= 1'b1;
        end
        else if (ce)
        begin
            if (cam.exposure_start)
            begin
                frame_trig_wait <= 1'b0;
            end
            else if (cam.image_out_done)
            begin
                frame_trig_wait <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            exposure_active <= 1'b0;
        end
        else if (ce)
        begin
            if (cam.exposure_start)
            begin
                exposure_active <= 1'b1;
            end
            else if (cam.exposure_end)
            begin
                exposure_active <= 1'b0;
            end
        end
    end

    // low while an image goes to the host
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            acq_trig_wait <= 1'b1;
            acq_trig_int <= 1'b0;
        end
        else if (ce)
        begin
            acq_trig_int <= cam.transfer_start;
            if (cam.transfer_start)
            begin
                acq_trig_wait <= 1'b0;
            end
            else if (cam.transfer_done)
            begin
                acq_trig_wait <= 1'b1;
            end
        end
    end

    // accepted trigger delayed by the programmed cycles; one in flight
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dly_busy <= 1'b0;
            dly_cnt <= '0;
            frame_trig_int <= 1'b0;
        end
        else if (ce)
        begin
            frame_trig_int <= 1'b0;
            if (dly_busy)
            begin
                if (dly_cnt == '0)
                begin
                    frame_trig_int <= 1'b1;
                    dly_busy <= 1'b0;
                end
                else
                begin
                    dly_cnt <= dly_cnt - 1'b1;
                end
            end
            else if (cam.trigger_accepted)
            begin
                if (trig_delay == '0)
                begin
                    frame_trig_int <= 1'b1;
                end
                else
                begin
                    dly_busy <= 1'b1;
                    dly_cnt <= trig_delay - 1'b1;
                end
            end
        end
    end

    // --------------------------------------------------------------
    // debounce: a new level must persist deb_time + 1 cycles
    // --------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            deb_level <= 2'b00;
            deb_cnt[0] <= '0;
            deb_cnt[1] <= '0;
        end
        else if (ce)
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (raw_line[i] == deb_level[i])
                begin
                    deb_cnt[i] <= '0;
                end
                else if (deb_cnt[i] >= deb_time)
                begin
                    deb_level[i] <= raw_line[i];
                    deb_cnt[i] <= '0;
                end
                else
                begin
                    deb_cnt[i] <= deb_cnt[i] + 1'b1;
                end
            end
        end
    end

    // --------------------------------------------------------------
    // one-second square wave, half period each level
    // --------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pps_cnt <= '0;
            pps <= 1'b0;
        end
        else if (ce)
        begin
            if (pps_cnt == PPS_LAST)
            begin
                pps_cnt <= '0;
                pps <= !pps;
            end
            else
            begin
                pps_cnt <= pps_cnt + 1'b1;
            end
        end
    end

    // --------------------------------------------------------------
    // output lines: registered mux, so a new selector lands on an edge
    // --------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            opto_output_line <= 1'b1;
            bidir_collector_line_out <= 1'b0;
            bidir_collector_line_oe <= 1'b0;
        end
        else if (ce)
        begin
            opto_output_line <= pick(src, sel_opto);
            bidir_collector_line_out <= 1'b0;
            // open collector: pull low only while the source is low
            bidir_collector_line_oe <= bidir_drive_en && !pick(src, sel_bidir);
        end
    end

endmodule

`default_nettype wire

// ### cols_top_bench.sv
// self-checking bench for the line source select block
`default_nettype none
module cols_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import cols_pkg::*;
    localparam int HALF = 8;
    logic hclk;
    logic hresetn;
    cols_ahb_req_t req;
    cols_ahb_req_t ahb;
    cols_cam_t cam;
    logic [31:0] hrdata;
    logic hreadyout;
    logic opto_in;
    logic sink;
    logic line_lvl;
    logic opto_out;
    logic oc_out;
    logic oc_oe;
    logic oe_s;
    logic s;
    logic [31:0] q;
    logic [31:0] d;
    logic [11:0] a;
    int n;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    int mreg [4] = '{32'h0, 32'h0, 32'h10, 32'h0};
    int msk [4] = '{32'hF0F, 32'h7, 32'hFFFF, 32'hFFFF};
    logic [11:0] ev [8] = '{12'h090, 12'h071, 12'h291, 12'h280,
        12'h360, 12'h351, 12'h461, 12'h480};
    always_comb
    begin
        ahb = req;
        ahb.hready = hreadyout;
    end
    cols_top #(.PPS_HALF_CYCLES(HALF), .DEB_W(16), .DLY_W(16)) u_cols_top (
        .hclk(hclk), .hresetn(hresetn), .ce(1'h1), .ahb_req(ahb), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(), .cam(cam), .opto_input_line(opto_in),
        .bidir_collector_line_in(line_lvl), .opto_output_line(opto_out),
        .bidir_collector_line_out(oc_out), .bidir_collector_line_oe(oc_oe));
    cols_ext_model u_cols_ext_model (.oe(oc_oe), .sink(sink), .level(line_lvl));
    initial
    begin
        hclk = 1'h0;
        forever #4 hclk = ~hclk;
    end
    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            n_mismatch = n_mismatch + 1;
            results();
        end
    end
    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("mismatches=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // single word transfer; reads are compared with the register model
    task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        int i;
        i = int'(ad[11:2]);
        req.hsel <= 1'h1;
        req.htrans <= 2'h2;
        req.hwrite <= w;
        req.hsize <= 3'h2;
        req.haddr <= {20'h00000, ad};
        do @(negedge hclk); while (hreadyout !== 1'h1);
        @(posedge hclk);
        req.htrans <= 2'h0;
        req.hwdata <= wd;
        do @(negedge hclk); while (hreadyout !== 1'h1);
        q = hrdata;
        @(posedge hclk);
        if (w && i < 4)
        begin
            mreg[i] = wd & msk[i];
            if (i == 0 && wd[3:0] == 4'hF)
                mreg[0] = mreg[0] & 32'hF00;
            if (i == 0 && wd[11:8] == 4'hF)
                mreg[0] = mreg[0] & 32'h00F;
        end
        if (!w)
            chk(q, (i < 4) ? mreg[i] : 32'h0);
    endtask
    // line level two edges after the stimulus edge
    task automatic see(input logic e);
        @(posedge hclk);
        cam[10:5] <= 6'h00;
        @(posedge hclk);
        @(negedge hclk);
        oe_s = oc_oe;
        chk(opto_out, e);
        @(posedge hclk);
    endtask
    // edges from the stimulus edge until the line goes high
    task automatic meas(input int e);
        int k;
        k = 0;
        do
        begin
            @(posedge hclk);
            cam[10:5] <= 6'h00;
            k = k + 1;
            @(negedge hclk);
            s = opto_out;
        end
        while (s !== 1'h1 && k < 100);
        @(posedge hclk);
        chk(k, e);
    endtask
    // ------------------------------------------------
    // sequence
    // ------------------------------------------------
    initial
    begin
        hresetn = 1'h0;
        req = '0;
        cam = '0;
        opto_in = 1'h0;
        sink = 1'h0;
        d = $urandom(8);
        repeat (12) @(posedge hclk);
        chk({oc_oe, oc_out, opto_out}, 32'h1);
        hresetn <= 1'h1;
        for (int i = 0; i < 6; i++)
        begin
            a = (i == 4) ? 12'h020 : 12'(i * 4);
            bus(1'h0, a, 32'h0);
            d = (i == 0) ? 32'hF0F : $urandom;
            bus(1'h1, a, d);
            bus(1'h0, a, 32'h0);
        end
        foreach (ev[k])
        begin
            bus(1'h1, 12'h000, {28'h0, ev[k][11:8]});
            cam[ev[k][7:4]] <= 1'h1;
            see(ev[k][0]);
        end
        for (int k = 0; k < 5; k++)
        begin
            bus(1'h1, 12'h000, (k == 0) ? 32'h5 : 32'h9 + k);
            repeat (3)
            begin
                d = $urandom;
                cam[4 - k] <= d[0];
                see(d[0]);
            end
        end
        for (int k = 0; k < 4; k++)
        begin
            bus(1'h1, 12'h004, 32'h4 + k);
            bus(1'h1, 12'h000, 32'h908 + k[1]);
            see(k[0] | k[1]);
            chk(oe_s, !k[1]);
        end
        bus(1'h1, 12'h004, 32'h0);
        bus(1'h1, 12'h008, 32'h3);
        bus(1'h1, 12'h000, 32'h6);
        opto_in <= 1'h1;
        meas(5);
        opto_in <= 1'h0;
        repeat (3) @(posedge hclk);
        opto_in <= 1'h1;
        see(1'h1);
        bus(1'h1, 12'h000, 32'h7);
        sink <= 1'h1;
        repeat (6) @(posedge hclk);
        see(1'h0);
        sink <= 1'h0;
        meas(5);
        for (int k = 0; k < 3; k++)
        begin
            d = (k == 0) ? 32'h0 : $urandom_range(20, 1);
            bus(1'h1, 12'h00C, d);
            bus(1'h1, 12'h000, 32'h1);
            cam[10] <= 1'h1;
            meas(d + 2);
        end
        bus(1'h1, 12'h000, 32'hE);
        @(negedge hclk);
        for (int k = 0; k < 3; k++)
        begin
            s = opto_out;
            n = 0;
            do
            begin
                @(negedge hclk);
                n = n + 1;
            end
            while (opto_out === s && n < 100);
            if (k > 0)
                chk(n, HALF);
        end
        @(posedge hclk);
        results();
    end
endmodule
`default_nettype wire

// ### cols_top_properties.sv
// checker for the line source outputs and register bus timing
`default_nettype none
module cols_chk #(
    parameter int PPS_HALF_CYCLES = 8,
    parameter int DEB_W = 16,
    parameter int DLY_W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire cols_pkg::cols_ahb_req_t ahb_req,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire cols_pkg::cols_cam_t cam,
    input wire logic opto_input_line,
    input wire logic bidir_collector_line_in,
    input wire logic opto_output_line,
    input wire logic bidir_collector_line_out,
    input wire logic bidir_collector_line_oe
);
    import cols_pkg::*;
    logic taken;
    logic wr_pend;
    logic [9:0] wa;
    logic [3:0] sel_o;
    logic [3:0] sel_b;
    logic [2:0] ctl;
    // ------------------------------------------------
    // shadow of selector and control registers
    // ------------------------------------------------
    assign taken = ce && ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'h0;
            wa <= 10'h000;
        end
        else
        begin
            wr_pend <= taken && ahb_req.hwrite;
            wa <= ahb_req.haddr[11:2];
        end
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sel_o <= 4'h0;
            sel_b <= 4'h0;
            ctl <= 3'h0;
        end
        else if (wr_pend && wa == 10'h000)
        begin
            sel_o <= (ahb_req.hwdata[3:0] == 4'hF) ? 4'h0 : ahb_req.hwdata[3:0];
            sel_b <= (ahb_req.hwdata[11:8] == 4'hF) ? 4'h0 : ahb_req.hwdata[11:8];
        end
        else if (wr_pend && wa == 10'h001)
        begin
            ctl <= ahb_req.hwdata[2:0];
        end
    end
    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    AST_RD_WAIT: assert property (
        taken && !ahb_req.hwrite |=> !hreadyout ##1 hreadyout)
        else $error("bad read wait");
    AST_TRIG_LO: assert property (
        cam.exposure_start ##1 sel_o == 4'h0 |=> !opto_output_line)
        else $error("trigger wait not low");
    AST_TRIG_HI: assert property (
        cam.image_out_done && !cam.exposure_start ##1 sel_o == 4'h0 |=> opto_output_line)
        else $error("trigger wait not high");
    AST_EXP_HI: assert property (
        cam.exposure_start ##1 sel_o == 4'h2 |=> opto_output_line)
        else $error("exposure not high");
    AST_ACQ_INT: assert property (
        cam.transfer_start ##1 sel_o == 4'h4 |=> opto_output_line)
        else $error("transfer start missing");
    AST_FRAME_VALID_FLAG: assert property (
        sel_o == 4'h5 |=> opto_output_line == $past(cam.frame_valid_flag))
        else $error("frame valid not routed");
    AST_USER: assert property (
        sel_o == 4'h8 |=> opto_output_line == $past(ctl[0]))
        else $error("user level not routed");
    AST_OC: assert property (
        sel_b == 4'h9 |=> bidir_collector_line_oe == ($past(ctl[2]) && !$past(ctl[1])))
        else $error("collector enable wrong");
    AST_FIXED_LOW: assert property (
        !hresp && !bidir_collector_line_out)
        else $error("fixed low output high");
    cover property (cam.exposure_start && sel_o == 4'h0);
    cover property (taken && !ahb_req.hwrite);
    cover property (sel_o == 4'hE && $changed(opto_output_line));
endmodule
bind cols_top cols_chk #(.PPS_HALF_CYCLES(PPS_HALF_CYCLES), .DEB_W(DEB_W), .DLY_W(DLY_W))
    u_cols_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce), .ahb_req(ahb_req),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cam(cam),
    .opto_input_line(opto_input_line), .bidir_collector_line_in(bidir_collector_line_in),
    .opto_output_line(opto_output_line), .bidir_collector_line_out(bidir_collector_line_out),
    .bidir_collector_line_oe(bidir_collector_line_oe));
`default_nettype wire
